// [src/adcseq_pkg.sv]
package adcseq_pkg;
    // ============================================================
    // Register offsets (byte addresses on the AXI4-Lite slave)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MAXCONV = 8'h04;
    localparam logic [7:0] OFF_CHSEL0 = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFF_RESULT0 = 8'h40;
    // ============================================================
    // Control register fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_CASCADE = 1;
    localparam int CTRL_CONT_RUN = 2;
    localparam int CTRL_EVERY_OTHER1 = 3;
    localparam int CTRL_EVERY_OTHER2 = 4;
    localparam int CTRL_SW_START1 = 5;
    localparam int CTRL_SW_START2 = 6;
    localparam int CTRL_RESET_SEQ = 7;
    localparam int CTRL_EXT_EN = 8;
    localparam int CTRL_PWM_EN1 = 9;
    localparam int CTRL_PWM_EN2 = 10;
    localparam int CTRL_CLKDIV_LSB = 16;
    localparam int CTRL_ACQ_LSB = 20;
    localparam int CTRL_DIV_W = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK = 32'h00ff_07ff; // Start bits must be writable
    localparam logic [7:0] MAXCONV_RESET = 8'h00;
    // ============================================================
    // Converter figures
    localparam int RES_W = 12;
    localparam logic [11:0] RES_FULL = 12'hfff;
    localparam logic [12:0] RES_STEPS = 13'h1000;
    localparam int CONV_PERIODS = 2;
    localparam logic [3:0] CONV_TICKS = 4'(CONV_PERIODS);
    localparam int STEPS = 16;
    localparam int HALF = 8;
    typedef enum {ADCS_IDLE, ADCS_ACQ, ADCS_CONV, ADCS_STORE} adcs_state_t;
endpackage

// [src/adcs_result_mem.sv]
`timescale 1ns/1ps
module adcs_result_mem (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic [11:0] wdata,
    input wire logic [3:0] raddr,
    output logic [11:0] rdata
);
    logic [11:0] mem_q [16];
    // ============================================================
    // Storage; read data registered
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_ent
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_q[i] <= 12'h000;
                end else if (we && waddr == 4'(i)) begin
                    mem_q[i] <= wdata;
                end
            end
        end
    endgenerate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 12'h000;
        end else begin
            rdata <= mem_q[raddr];
        end
    end
endmodule

// [src/adcs_top.sv]
`timescale 1ns/1ps
module adcs_top (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic FAST_PERIPHERAL_CLOCK_EN,
    input wire logic PWM_START_TRIGGER_ONE,
    input wire logic PWM_START_TRIGGER_TWO,
    input wire logic EXTERNAL_INT_LINE_TWO,
    input wire logic [12:0] ANALOG_CHANNEL_INPUT,
    input wire logic [12:0] LOW_REFERENCE_INPUT,
    output logic [3:0] MUX_SELECT,
    output logic SAMPLE_HOLD,
    output logic CONVERTER_CLOCK_ENABLE,
    output logic [1:0] SEQUENCE_DONE_EVENT,
    output logic IRQ,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    logic [31:0] ctrl_q, w_data_q, wd;
    logic [7:0] maxconv_q, aw_addr_q, ar_addr_q, wa;
    logic [3:0] chsel_q [16];
    logic [1:0] irq_stat_q, irq_mask_q, pend_q, toggle_q, done_q;
    logic [3:0] ptr_q [2];
    logic [3:0] cur_step_q, div_cnt_q, acq_cnt_q, conv_cnt_q;
    logic cur_seq_q, aw_hold_q, w_hold_q, rd_pend_q;
    adcseq_pkg::adcs_state_t state_q;
    logic [11:0] sample_q, res_rdata, clamped;
    logic res_we, tick, wr_fire, sel_seq, cascade;
    logic [1:0] trig, sw_start, seq_end, clr_irq;
    logic [3:0] last_step [2];
    logic [12:0] diff;

    assign cascade = ctrl_q[adcseq_pkg::CTRL_CASCADE];
    // ============================================================
    // AXI4-Lite write path: address and data taken in either order
    assign AWREADY = !aw_hold_q && !BVALID;
    assign WREADY = !w_hold_q && !BVALID;
    assign wr_fire = (aw_hold_q || AWVALID) && (w_hold_q || WVALID) && !BVALID;
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0;
            BVALID <= 1'b0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_addr_q <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_data_q <= WDATA;
            end
            aw_hold_q <= wr_fire ? 1'b0 : (aw_hold_q || AWVALID);
            w_hold_q <= wr_fire ? 1'b0 : (w_hold_q || WVALID);
            if (wr_fire) begin
                BVALID <= 1'b1;
            end else if (BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end
    assign BRESP = 2'b00;
    // Write address and data, held copy or live bus
    assign wa = aw_hold_q ? aw_addr_q : AWADDR;
    assign wd = w_hold_q ? w_data_q : WDATA;
    // Byte-lane aware write of the control word; start bits self-clear
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_q <= adcseq_pkg::CTRL_RESET;
            maxconv_q <= adcseq_pkg::MAXCONV_RESET;
            irq_mask_q <= 2'b00;
        end else begin
            ctrl_q[adcseq_pkg::CTRL_SW_START1] <= 1'b0;
            ctrl_q[adcseq_pkg::CTRL_SW_START2] <= 1'b0;
            ctrl_q[adcseq_pkg::CTRL_RESET_SEQ] <= 1'b0;
            if (wr_fire && wa == adcseq_pkg::OFF_CTRL) begin
                for (int b = 0; b < 4; b++) begin
                    if (WSTRB[b]) begin
                        ctrl_q[b*8 +: 8] <= wd[b*8 +: 8] & adcseq_pkg::CTRL_WMASK[b*8 +: 8];
                    end
                end
            end
            if (wr_fire && wa == adcseq_pkg::OFF_MAXCONV && WSTRB[0]) begin
                maxconv_q <= wd[7:0];
            end
            if (wr_fire && wa == adcseq_pkg::OFF_IRQ_MASK && WSTRB[0]) begin
                irq_mask_q <= wd[1:0];
            end
        end
    end
    // Channel selection words, four steps per word
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_chsel
            always_ff @(posedge CLOCK or negedge RSTN) begin
                if (!RSTN) begin
                    chsel_q[g] <= 4'h0;
                end else if (wr_fire && wa == adcseq_pkg::OFF_CHSEL0 + 8'(4 * (g / 4))
                             && WSTRB[(g % 4) / 2]) begin
                    chsel_q[g] <= wd[(g % 4) * 4 +: 4];
                end
            end
        end
    endgenerate
    assign sw_start = {ctrl_q[adcseq_pkg::CTRL_SW_START2], ctrl_q[adcseq_pkg::CTRL_SW_START1]};
    // ============================================================
    // AXI4-Lite read path; result reads take no extra cycle, the memory read starts as AR is taken
    assign ARREADY = !rd_pend_q && !RVALID;
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            rd_pend_q <= 1'b0;
            ar_addr_q <= 8'h00;
            RVALID <= 1'b0;
            RDATA <= 32'h0;
        end else begin
            if (ARVALID && ARREADY) begin
                rd_pend_q <= 1'b1;
                ar_addr_q <= ARADDR;
            end
            if (rd_pend_q) begin
                rd_pend_q <= 1'b0;
                RVALID <= 1'b1;
                if (ar_addr_q >= adcseq_pkg::OFF_RESULT0) begin
                    RDATA <= (ar_addr_q < adcseq_pkg::OFF_RESULT0 + 8'h40)
                             ? {20'h0, res_rdata} : 32'h0;
                end else if (ar_addr_q == adcseq_pkg::OFF_CTRL) begin
                    RDATA <= ctrl_q;
                end else if (ar_addr_q == adcseq_pkg::OFF_MAXCONV) begin
                    RDATA <= {24'h0, maxconv_q};
                end else if (ar_addr_q >= adcseq_pkg::OFF_CHSEL0 && ar_addr_q < 8'h18) begin
                    RDATA <= {16'h0, chsel_q[{ar_addr_q[3:2] - 2'd2, 2'd3}],
                              chsel_q[{ar_addr_q[3:2] - 2'd2, 2'd2}],
                              chsel_q[{ar_addr_q[3:2] - 2'd2, 2'd1}],
                              chsel_q[{ar_addr_q[3:2] - 2'd2, 2'd0}]};
                end else if (ar_addr_q == adcseq_pkg::OFF_STATUS) begin
                    RDATA <= {16'h0, ptr_q[1], ptr_q[0], pend_q,
                              state_q != adcseq_pkg::ADCS_IDLE, cur_seq_q, cur_step_q};
                end else if (ar_addr_q == adcseq_pkg::OFF_IRQ_STAT) begin
                    RDATA <= {30'h0, irq_stat_q};
                end else if (ar_addr_q == adcseq_pkg::OFF_IRQ_MASK) begin
                    RDATA <= {30'h0, irq_mask_q};
                end else begin
                    RDATA <= 32'h0; // Unmapped reads return zero with OKAY
                end
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end
    assign RRESP = 2'b00;
    // ============================================================
    // Triggers: PWM one feeds sequencer 1, PWM two feeds sequencer 2 only when not cascaded
    always_comb begin
        trig[0] = sw_start[0]
            || (ctrl_q[adcseq_pkg::CTRL_PWM_EN1] && PWM_START_TRIGGER_ONE)
            || (ctrl_q[adcseq_pkg::CTRL_EXT_EN] && EXTERNAL_INT_LINE_TWO);
        trig[1] = !cascade && (sw_start[1]
            || (ctrl_q[adcseq_pkg::CTRL_PWM_EN2] && PWM_START_TRIGGER_TWO));
    end
    // Per-sequencer last step from the max conversion field
    assign last_step[0] = cascade ? maxconv_q[3:0] : {1'b0, maxconv_q[2:0]};
    assign last_step[1] = {1'b1, maxconv_q[6:4]};
    assign seq_end[0] = res_we && !cur_seq_q && cur_step_q == last_step[0];
    assign seq_end[1] = res_we && cur_seq_q && cur_step_q == last_step[1];
    // Pending requests; a new trigger wins over the service clear
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            pend_q <= 2'b00;
        end else begin
            for (int s = 0; s < 2; s++) begin
                if (trig[s]) begin
                    pend_q[s] <= 1'b1;
                end else if (seq_end[s] && !ctrl_q[adcseq_pkg::CTRL_CONT_RUN]) begin
                    pend_q[s] <= 1'b0;
                end
            end
        end
    end
    // ============================================================
    // Fast-clock divider: one tick per converter clock period
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            div_cnt_q <= 4'h0;
        end else if (FAST_PERIPHERAL_CLOCK_EN) begin
            div_cnt_q <= tick ? 4'h0 : div_cnt_q + 4'h1;
        end
    end
    assign tick = FAST_PERIPHERAL_CLOCK_EN
        && div_cnt_q == ctrl_q[adcseq_pkg::CTRL_CLKDIV_LSB +: adcseq_pkg::CTRL_DIV_W];
    assign CONVERTER_CLOCK_ENABLE = tick && ctrl_q[adcseq_pkg::CTRL_ENABLE];
    // Sequencer 1 has priority; only one conversion in flight
    assign sel_seq = !pend_q[0] && pend_q[1];
    // Saturating conversion of the input code
    assign diff = ANALOG_CHANNEL_INPUT - LOW_REFERENCE_INPUT;
    always_comb begin
        if (ANALOG_CHANNEL_INPUT <= LOW_REFERENCE_INPUT) begin
            clamped = 12'h000;
        end else if (ANALOG_CHANNEL_INPUT >= adcseq_pkg::RES_STEPS) begin
            clamped = adcseq_pkg::RES_FULL;
        end else begin
            clamped = diff[11:0];
        end
    end
    // ============================================================
    // Shared converter control
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= adcseq_pkg::ADCS_IDLE;
            cur_step_q <= 4'h0;
            cur_seq_q <= 1'b0;
            acq_cnt_q <= 4'h0;
            conv_cnt_q <= 4'h0;
            sample_q <= 12'h000;
        end else begin
            case (state_q)
                adcseq_pkg::ADCS_IDLE: begin
                    if (ctrl_q[adcseq_pkg::CTRL_ENABLE] && pend_q != 2'b00) begin
                        cur_seq_q <= sel_seq;
                        cur_step_q <= ptr_q[sel_seq];
                        acq_cnt_q <= 4'h0;
                        state_q <= adcseq_pkg::ADCS_ACQ;
                    end
                end
                adcseq_pkg::ADCS_ACQ: begin
                    if (tick) begin
                        if (acq_cnt_q == ctrl_q[adcseq_pkg::CTRL_ACQ_LSB +: 4]) begin
                            sample_q <= clamped;
                            conv_cnt_q <= 4'h0;
                            state_q <= adcseq_pkg::ADCS_CONV;
                        end else begin
                            acq_cnt_q <= acq_cnt_q + 4'h1;
                        end
                    end
                end
                adcseq_pkg::ADCS_CONV: begin
                    if (tick) begin
                        conv_cnt_q <= conv_cnt_q + 4'h1;
                        if (conv_cnt_q == adcseq_pkg::CONV_TICKS - 4'h1) begin
                            state_q <= adcseq_pkg::ADCS_STORE;
                        end
                    end
                end
                adcseq_pkg::ADCS_STORE: begin
                    state_q <= adcseq_pkg::ADCS_IDLE;
                end
                default: begin
                    state_q <= adcseq_pkg::ADCS_IDLE;
                end
            endcase
        end
    end
    assign SAMPLE_HOLD = state_q == adcseq_pkg::ADCS_ACQ;
    assign MUX_SELECT = cascade ? chsel_q[cur_step_q]
        : {cur_seq_q, chsel_q[cur_step_q][2:0]};
    assign res_we = state_q == adcseq_pkg::ADCS_STORE;
    // Step pointers per sequencer, wrap at the end of the session
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ptr_q[0] <= 4'h0;
            ptr_q[1] <= 4'h8;
        end else if (ctrl_q[adcseq_pkg::CTRL_RESET_SEQ]) begin
            ptr_q[0] <= 4'h0;
            ptr_q[1] <= 4'h8;
        end else if (res_we) begin
            if (seq_end[cur_seq_q]) begin
                ptr_q[cur_seq_q] <= cur_seq_q ? 4'h8 : 4'h0;
            end else begin
                ptr_q[cur_seq_q] <= cur_step_q + 4'h1;
            end
        end
    end
    // Done events, every-other counting and sticky interrupt status
    assign clr_irq = (wr_fire && wa == adcseq_pkg::OFF_IRQ_STAT && WSTRB[0]) ? wd[1:0] : 2'b00;
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            done_q <= 2'b00;
            toggle_q <= 2'b00;
            irq_stat_q <= 2'b00;
        end else begin
            done_q <= seq_end;
            for (int s = 0; s < 2; s++) begin
                if (seq_end[s]) begin
                    toggle_q[s] <= !toggle_q[s];
                end
                if (seq_end[s] && (!ctrl_q[adcseq_pkg::CTRL_EVERY_OTHER1 + s] || toggle_q[s])) begin
                    irq_stat_q[s] <= 1'b1;
                end else if (clr_irq[s]) begin
                    irq_stat_q[s] <= 1'b0;
                end
            end
        end
    end
    assign SEQUENCE_DONE_EVENT = done_q;
    assign IRQ = |(irq_stat_q & irq_mask_q);

    adcs_result_mem u_mem (
        .clk(CLOCK),
        .rst_n(RSTN),
        .we(res_we),
        .waddr(cur_step_q),
        .wdata(sample_q),
        .raddr(ARREADY ? ARADDR[5:2] : ar_addr_q[5:2]), // Memory read starts as AR is taken
        .rdata(res_rdata)
    );
    // ============================================================
    // Checks
    conv_width_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        $rose(res_we) |-> $past(state_q == adcseq_pkg::ADCS_CONV))
        else $error("store without conversion");
    no_start_off_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (state_q == adcseq_pkg::ADCS_IDLE && !ctrl_q[0]) |=> state_q == adcseq_pkg::ADCS_IDLE)
        else $error("started while disabled");
    pend_hold_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        trig[0] |=> pend_q[0])
        else $error("trigger lost");
    sat_high_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (ANALOG_CHANNEL_INPUT > LOW_REFERENCE_INPUT && ANALOG_CHANNEL_INPUT >= 13'h1000)
        |-> clamped == 12'hfff)
        else $error("no saturation");
    mux_group_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (!cascade && state_q == adcseq_pkg::ADCS_ACQ) |-> MUX_SELECT[3] == cur_seq_q)
        else $error("channel from wrong group");
    dual_seq_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        cascade |-> !trig[1])
        else $error("second sequencer active in cascade");
    done_pulse_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        seq_end[0] |=> SEQUENCE_DONE_EVENT[0] ##1 !SEQUENCE_DONE_EVENT[0])
        else $error("done event not one pulse");
    store_once_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        res_we |=> !res_we)
        else $error("overlapping conversions");
    irq_set_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (seq_end[0] && !ctrl_q[3]) |=> irq_stat_q[0])
        else $error("interrupt status not set");
endmodule

// [verif/adcs_trig_model.sv]
`timescale 1ns/1ps
// ============================================================
// Trigger sources and analog front end seen by the sequencer
module adcs_trig_model (
    input wire logic clk,
    input wire logic [2:0] fire,
    input wire logic [3:0] mux_select,
    output logic pwm_one,
    output logic pwm_two,
    output logic ext_line,
    output logic [12:0] analog
);
    // One-cycle trigger pulses, each source on its own line
    always_ff @(posedge clk) begin
        pwm_one <= fire[0];
        pwm_two <= fire[1];
        ext_line <= fire[2];
    end
    // Level depends on the selected channel, so a wrong mux shows in the result
    assign analog = 13'(mux_select) * 13'h0123;
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ps
// ============================================================
// Register-level bench for the sequencer
module tb_top;
    logic clock = 1'b0, rstn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rd;
    logic [2:0] fire = 3'h0;
    logic [12:0] low_ref = 13'h0000;
    logic [12:0] analog;
    logic t1, t2, tx, awready, wready, bvalid, arready, rvalid, sh, irq, cce;
    logic fast_en = 1'b1;
    logic [1:0] done, bresp, rresp;
    logic [31:0] rdata, w;
    logic [3:0] mux;
    int miscompares = 0, total_checks = 0, dn0 = 0, dn1 = 0, sh_cnt = 0;
    always #50 clock = ~clock;
    adcs_trig_model u_src (.clk(clock), .fire(fire), .mux_select(mux), .pwm_one(t1),
        .pwm_two(t2), .ext_line(tx), .analog(analog));
    adcs_top dut (.CLOCK(clock), .RSTN(rstn), .FAST_PERIPHERAL_CLOCK_EN(fast_en),
        .PWM_START_TRIGGER_ONE(t1), .PWM_START_TRIGGER_TWO(t2), .EXTERNAL_INT_LINE_TWO(tx),
        .ANALOG_CHANNEL_INPUT(analog), .LOW_REFERENCE_INPUT(low_ref), .MUX_SELECT(mux),
        .SAMPLE_HOLD(sh), .CONVERTER_CLOCK_ENABLE(cce), .SEQUENCE_DONE_EVENT(done), .IRQ(irq),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
    // Event counters sample at the edge, before that edge's updates land
    always @(posedge clock) begin
        if (done[0] === 1'b1) dn0++;
        if (done[1] === 1'b1) dn1++;
        if (sh === 1'b1) sh_cnt++;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
            miscompares++;
        end
    endtask
    task automatic hang();
        miscompares++;
        report_and_stop();
    endtask
    // Each channel is held until its own handshake edge; readiness is looked at mid-cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ah, wh, bh;
        n = 0;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(negedge clock);
            ah = awvalid & awready; wh = wvalid & wready; bh = bvalid;
            @(posedge clock);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            n++;
        end while (!bh && n < 50);
        bready <= 1'b0;
        if (!bh) hang();
        @(posedge clock); // Idle edge so a next call never re-drives bready in this step
    endtask
    task automatic rdreg(input logic [7:0] a, output logic [31:0] d);
        int n;
        logic ah, rh;
        n = 0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(negedge clock);
            ah = arvalid & arready; rh = rvalid; d = rdata;
            @(posedge clock);
            if (ah) arvalid <= 1'b0;
            n++;
        end while (!rh && n < 50);
        rready <= 1'b0;
        if (!rh) hang();
        @(posedge clock); // Idle edge so a next call never re-drives rready in this step
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        rdreg(a, rd);
        check(rd, exp);
    endtask
    task automatic pulse(input logic [2:0] f);
        fire <= f;
        @(posedge clock);
        fire <= 3'h0;
    endtask
    task automatic wait_cnt(ref int cnt, input int target);
        int n;
        for (n = 0; n < 500 && cnt < target; n++) @(posedge clock);
        if (cnt < target) hang();
    endtask
    // Transfer function with clamping at both ends, in LSB steps of the span
    function automatic logic [31:0] exp_res(input int ch, input logic [12:0] lo);
        logic [12:0] a;
        a = 13'(ch) * 13'h0123;
        if (a <= lo) return 32'h0;
        if (a >= 13'h1000) return 32'h0000_0fff;
        return 32'(a - lo);
    endfunction
    function automatic int ch_of(input int n);
        return (n < 12) ? ((n * 7) % 16) : 3;
    endfunction
    initial begin
        logic [31:0] s1;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        // Defaults after reset and an unmapped slot
        rdchk(adcseq_pkg::OFF_CTRL, adcseq_pkg::CTRL_RESET);
        rdchk(adcseq_pkg::OFF_MAXCONV, 32'(adcseq_pkg::MAXCONV_RESET));
        rdchk(8'hfc, 32'h0);
        @(negedge clock);
        check(32'(cce), 32'h0);
        check(32'({bresp, rresp}), 32'h0);
        @(posedge clock);
        $display("test reset done");
        // Cascaded sixteen-step session with repeated channels, software start
        for (int k = 0; k < 4; k++) begin
            w = 32'h0;
            for (int j = 0; j < 4; j++) w[4 * j +: 4] = 4'(ch_of(4 * k + j));
            wr(adcseq_pkg::OFF_CHSEL0 + 8'(4 * k), w);
        end
        wr(adcseq_pkg::OFF_MAXCONV, 32'h0000_000f);
        wr(adcseq_pkg::OFF_CTRL, 32'h0000_0023);
        wait_cnt(dn0, 1);
        repeat (50) @(posedge clock);
        check(32'(dn0), 32'h1);
        check(32'(dn1), 32'h0);
        for (int n = 0; n < 16; n++) begin
            rdreg(adcseq_pkg::OFF_RESULT0 + 8'(4 * n), rd);
            check(rd, exp_res(ch_of(n), 13'h0000));
        end
        $display("test cascade done");
        // Dual mode, both PWM triggers in the same cycle, raised low reference
        low_ref <= 13'h0200;
        wr(adcseq_pkg::OFF_IRQ_STAT, 32'h0000_0003);
        wr(adcseq_pkg::OFF_CHSEL0, 32'h0000_0041);
        wr(adcseq_pkg::OFF_CHSEL0 + 8'h08, 32'h0000_0fc9);
        wr(adcseq_pkg::OFF_MAXCONV, 32'h0000_0021);
        wr(adcseq_pkg::OFF_CTRL, 32'h0000_0601);
        pulse(3'b011);
        wait_cnt(dn0, 2);
        wait_cnt(dn1, 1);
        rdchk(adcseq_pkg::OFF_RESULT0, exp_res(1, 13'h0200));
        rdchk(adcseq_pkg::OFF_RESULT0 + 8'h04, exp_res(4, 13'h0200));
        rdchk(adcseq_pkg::OFF_RESULT0 + 8'h20, exp_res(9, 13'h0200));
        rdchk(adcseq_pkg::OFF_RESULT0 + 8'h24, exp_res(12, 13'h0200));
        rdchk(adcseq_pkg::OFF_RESULT0 + 8'h28, exp_res(15, 13'h0200));
        $display("test dual done");
        // Interrupt status, mask and write-one-to-clear
        rdchk(adcseq_pkg::OFF_IRQ_STAT, 32'h0000_0003);
        @(negedge clock);
        check(32'(irq), 32'h0);
        @(posedge clock);
        wr(adcseq_pkg::OFF_IRQ_MASK, 32'h0000_0003);
        @(negedge clock);
        check(32'(irq), 32'h1);
        @(posedge clock);
        wr(adcseq_pkg::OFF_IRQ_STAT, 32'h0000_0003);
        rdchk(adcseq_pkg::OFF_IRQ_STAT, 32'h0);
        @(negedge clock);
        check(32'(irq), 32'h0);
        @(posedge clock);
        $display("test irq done");
        // Every-other interrupt over two external-line sessions, acquisition prescale 3
        wr(adcseq_pkg::OFF_MAXCONV, 32'h0000_0000);
        wr(adcseq_pkg::OFF_CTRL, 32'h0030_0109);
        sh_cnt = 0;
        pulse(3'b100);
        wait_cnt(dn0, 3);
        check(32'(sh_cnt), 32'h4);
        rdreg(adcseq_pkg::OFF_IRQ_STAT, s1);
        wr(adcseq_pkg::OFF_IRQ_STAT, 32'h0000_0003);
        pulse(3'b100);
        wait_cnt(dn0, 4);
        rdreg(adcseq_pkg::OFF_IRQ_STAT, rd);
        check(32'(s1[0] ^ rd[0]), 32'h1);
        check(32'(dn1), 32'h1);
        // Converter clock enable follows the fast-clock enable pulse
        fast_en <= 1'b0;
        @(negedge clock);
        check(32'(cce), 32'h0);
        @(posedge clock);
        fast_en <= 1'b1;
        @(negedge clock);
        check(32'(cce), 32'h1);
        @(posedge clock);
        $display("test every_other done");
        report_and_stop();
    end
endmodule
